// ==== tb/tb_pcr_regs.sv ====
`timescale 1ns/10ps
module tb_pcr_regs;
  import pcr_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } pcr_tb_row_s;
  localparam logic [7:0] KEY = 8'h5a; // value is arbitrary
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff, q;
  logic reg_rvalid_ff, seq_powerup = 0, seq_from_suspend = 0, seq_wait_pwr_en = 0;
  logic seq_active = 0, seq_suspend = 0, seq_en_we = 0, power_fail_out_n = 1;
  logic factory_seal = 0, coin_cell_done = 0;
  logic [4:0] seq_en_val = 5'h00;
  logic [7:0] rail_state = 8'h00;
  logic [5:0] conv_en_ff;
  logic coin_cell_pulse_ff, rails_off_ff;
  logic [1:0] dev_state_ff;
  int miscompares = 0, tests_run = 0;
  pcr_tb_row_s rows[5] = '{'{8'h06, 8'hfe, 8'h02}, '{8'h06, 8'h00, 8'h00},
    '{8'h07, 8'hff, 8'h00}, '{8'h11, 8'h0f, 8'h00}, '{8'h20, 8'hff, 8'h00}};

  pcr_regs #(.UNLOCK_KEY_VALUE(KEY)) dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .seq_powerup(seq_powerup),
    .seq_from_suspend(seq_from_suspend), .seq_wait_pwr_en(seq_wait_pwr_en),
    .seq_active(seq_active), .seq_suspend(seq_suspend), .seq_en_we(seq_en_we),
    .seq_en_val(seq_en_val), .rail_state(rail_state), .power_fail_out_n(power_fail_out_n),
    .factory_seal(factory_seal), .coin_cell_done(coin_cell_done), .conv_en_ff(conv_en_ff),
    .coin_cell_pulse_ff(coin_cell_pulse_ff), .rails_off_ff(rails_off_ff),
    .dev_state_ff(dev_state_ff));

  always #25 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 0;
  endtask

  // invalid strobe turns the result unknown so it never matches
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    tick(1);
    reg_rd = 1;
    reg_addr = a;
    tick(1);
    reg_rd = 0;
    r = reg_rvalid_ff ? reg_rdata_ff : 8'hxx;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(3000 * 50);
    miscompares++;
    finish_test();
  end

  initial begin
    tick(5);
    sys_rst = 0;
    foreach (rows[i]) begin
      rd(rows[i].addr ^ 8'h00, q);
      check(q, 8'h00);
    end
    check({2'h0, conv_en_ff}, 8'h00);
    tick(1);
    check({7'h0, reg_rvalid_ff}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, q);
      check(q, rows[i].exp);
    end
    wr(8'h10, KEY);
    rd(8'h10, q);
    check(q, 8'h00);
    wr(8'h10, KEY);
    wr(8'h11, 8'hff);
    check({2'h0, conv_en_ff}, 8'h3f);
    rd(8'h11, q);
    check(q, 8'h3f);
    factory_seal = 1;
    wr(8'h10, KEY);
    wr(8'h11, 8'h00);
    check({2'h0, conv_en_ff}, 8'h30);
    seq_en_val = 5'h00;
    seq_en_we = 1;
    tick(1);
    seq_en_we = 0;
    tick(1);
    check({2'h0, conv_en_ff}, 8'h30);
    factory_seal = 0;
    seq_en_val = 5'h15;
    seq_en_we = 1;
    tick(1);
    seq_en_we = 0;
    rd(8'h11, q);
    check(q, 8'h35);
    wr(8'h10, KEY);
    wr(8'h11, 8'h00);
    check({2'h0, conv_en_ff}, 8'h00);
    wr(8'h10, KEY ^ 8'h01);
    wr(8'h11, 8'h3f);
    check({2'h0, conv_en_ff}, 8'h00);
    // measurement before trusting the charge state
    wr(8'h06, 8'h01);
    check({7'h0, coin_cell_pulse_ff}, 8'h01);
    tick(1);
    check({7'h0, coin_cell_pulse_ff}, 8'h00);
    rd(8'h06, q);
    check(q, 8'h01);
    wr(8'h06, 8'h01);
    check({7'h0, coin_cell_pulse_ff}, 8'h00);
    coin_cell_done = 1;
    tick(1);
    coin_cell_done = 0;
    rd(8'h06, q);
    check(q, 8'h00);
    wr(8'h06, 8'h00);
    check({7'h0, coin_cell_pulse_ff}, 8'h00);
    wr(8'h10, KEY);
    wr(8'h11, 8'h0f);
    power_fail_out_n = 0;
    tick(3);
    check({7'h0, rails_off_ff}, 8'h00);
    check({2'h0, conv_en_ff}, 8'h0f);
    factory_seal = 1;
    wr(8'h06, 8'h02);
    check({7'h0, rails_off_ff}, 8'h00);
    tick(1);
    check({7'h0, rails_off_ff}, 8'h01);
    check({2'h0, conv_en_ff}, 8'h00);
    seq_active = 1;
    tick(2);
    check({6'h0, dev_state_ff}, 8'h00);
    power_fail_out_n = 1;
    factory_seal = 0;
    seq_powerup = 1;
    tick(1);
    seq_powerup = 0;
    seq_active = 0;
    check({7'h0, rails_off_ff}, 8'h00);
    rd(8'h07, q);
    check(q, 8'h00);
    wr(8'h06, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seq_wait_pwr_en = (i == 1);
      seq_active = (i == 2);
      seq_suspend = (i == 3);
      tick(2);
      check({6'h0, dev_state_ff}, 8'(i));
    end
    seq_wait_pwr_en = 0;
    seq_active = 0;
    for (int i = 0; i < 3; i++) begin
      seq_suspend = 1;
      rail_state = (i == 0) ? 8'h83 : 8'h7e;
      tick(1);
      seq_suspend = 0;
      rail_state = 8'h00;
      tick(1);
      seq_powerup = 1;
      seq_from_suspend = (i == 0);
      tick(1);
      seq_powerup = 0;
      seq_from_suspend = 0;
      rd(8'h07, q);
      check(q, (i == 0) ? 8'h83 : 8'h00);
      if (i == 1) begin
        wr(8'h07, 8'hff);
        rd(8'h07, q);
        check(q, 8'h00);
      end
    end
    // reset in mid-run clears enables; an unkeyed write after it is refused
    wr(8'h10, KEY);
    wr(8'h11, 8'h3f);
    check({2'h0, conv_en_ff}, 8'h3f);
    sys_rst = 1;
    tick(2);
    check({2'h0, conv_en_ff}, 8'h00);
    check({7'h0, rails_off_ff}, 8'h00);
    check({6'h0, dev_state_ff}, 8'h00);
    sys_rst = 0;
    wr(8'h11, 8'h3f);
    rd(8'h11, q);
    check(q, 8'h00);
    finish_test();
  end
endmodule

// ==== verilog/pcr_flag_if.sv ====
`timescale 1ns/10ps
interface pcr_flag_if #(parameter int N = 8);
  logic powerup;
  logic from_suspend;
  logic in_suspend;
  logic [N-1:0] rail_en;
  logic [N-1:0] flags;

  modport core (output powerup, output from_suspend, output in_suspend, output rail_en,
    input flags);
  modport capture (input powerup, input from_suspend, input in_suspend, input rail_en,
    output flags);
endinterface

// ==== verilog/pcr_pkg.sv ====
package pcr_pkg;

  // register addresses
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_SUSPEND_RAIL_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h10;
  localparam logic [7:0] ADDR_CONVERTER_ENABLES = 8'h11;

  // reset values
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_SUSPEND_RAIL_FLAGS = 8'h00;
  localparam logic [7:0] RST_UNLOCK_KEY = 8'h00;
  localparam logic [7:0] RST_CONVERTER_ENABLES = 8'h00;

  // power_control fields
  localparam int BIT_COIN_CELL_MEASURE_START = 0;
  localparam int BIT_POWER_FAIL_SHUTDOWN_EN = 1;

  // converter_enables fields
  localparam int CONV_COUNT = 6;
  localparam int SEQ_CONV_COUNT = 5;
  localparam int BIT_BACKUP_BUCK_A_ENABLE = 4;
  localparam int BIT_BACKUP_BUCK_B_ENABLE = 5;

  // suspend_rail_flags layout, bit 0 up to bit 7
  localparam int FLAG_COUNT = 8;
  localparam int BIT_BUCK1_SUSPEND_FLAG = 0;
  localparam int BIT_BUCK2_SUSPEND_FLAG = 1;
  localparam int BIT_BUCK3_SUSPEND_FLAG = 2;
  localparam int BIT_BUCK_BOOST_SUSPEND_FLAG = 3;
  localparam int BIT_LINEAR_REG_SUSPEND_FLAG = 4;
  localparam int BIT_OUTPUT1_SUSPEND_FLAG = 5;
  localparam int BIT_OUTPUT2_SUSPEND_FLAG = 6;
  localparam int BIT_OUTPUT3_SUSPEND_FLAG = 7;

  // device state field codes
  typedef enum logic [1:0] {
    DS_TRANSITION = 2'h0,
    DS_WAIT_PWR_EN = 2'h1,
    DS_ACTIVE = 2'h2,
    DS_SUSPEND = 2'h3
  } pcr_dev_state_e;

  // power-fail state machine
  typedef enum logic [1:0] {
    PF_RUN = 2'b01,
    PF_OFF = 2'b10
  } pcr_pf_state_e;

endpackage

// ==== verilog/pcr_regs.sv ====
// Contract
// - shutdown bit clear ignores power-fail output
// - shutdown bit set, trip powers all rails off
// - writing one starts coin-cell measurement, self-clears
// - flag one when rail on during suspend
// - flag zero after off or disabled rail
// - flag bits ordered outputs, linear, converters; read-only
// - key unlocks protected writes; key reads zero
// - enable bits switch converters one through six
// - sequencer updates converter one to five enables
// - sealed device refuses disabling backup converters, except on a power-fail trip
// - state code transition, wait, active, suspend
`timescale 1ns/10ps
module pcr_regs
  import pcr_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY_VALUE = 8'h5a // value is arbitrary
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  // sequencer
  input wire logic seq_powerup,
  input wire logic seq_from_suspend,
  input wire logic seq_wait_pwr_en,
  input wire logic seq_active,
  input wire logic seq_suspend,
  input wire logic seq_en_we,
  input wire logic [SEQ_CONV_COUNT-1:0] seq_en_val,
  input wire logic [FLAG_COUNT-1:0] rail_state,
  // analog status
  input wire logic power_fail_out_n,
  input wire logic factory_seal,
  input wire logic coin_cell_done,
  // controls
  output logic [CONV_COUNT-1:0] conv_en_ff,
  output logic coin_cell_pulse_ff,
  output logic rails_off_ff,
  output logic [1:0] dev_state_ff
);

  logic power_fail_shutdown_en_ff;
  logic coin_cell_measure_start_ff;
  logic unlocked_ff;
  pcr_pf_state_e pf_state_ff;
  pcr_pf_state_e nxt_pf_state;
  logic [CONV_COUNT-1:0] nxt_conv_en;
  logic [7:0] nxt_rdata;
  pcr_dev_state_e nxt_dev_state;
  logic wr_ctl;
  logic wr_en;
  logic pf_trip;
  logic cc_start;

  pcr_flag_if #(.N(FLAG_COUNT)) flag_if ();

  assign flag_if.powerup = seq_powerup;
  assign flag_if.from_suspend = seq_from_suspend;
  assign flag_if.in_suspend = seq_suspend;
  assign flag_if.rail_en = rail_state;

  pcr_suspend_flags #(.N(FLAG_COUNT)) u_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .fi(flag_if.capture)
  );

  assign wr_ctl = reg_wr && (reg_addr == ADDR_POWER_CONTROL);
  assign wr_en = reg_wr && (reg_addr == ADDR_CONVERTER_ENABLES) && unlocked_ff;
  assign cc_start = wr_ctl && reg_wdata[BIT_COIN_CELL_MEASURE_START] &&
    !coin_cell_measure_start_ff;
  // trip only matters while the shutdown option is armed
  assign pf_trip = power_fail_shutdown_en_ff && !power_fail_out_n;

  // power_control, only bit 1 is stored from software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_fail_shutdown_en_ff <= RST_POWER_CONTROL[BIT_POWER_FAIL_SHUTDOWN_EN];
    end else if (wr_ctl) begin
      power_fail_shutdown_en_ff <= reg_wdata[BIT_POWER_FAIL_SHUTDOWN_EN];
    end
  end

  // measurement bit: set on write of one, cleared when done; set wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coin_cell_measure_start_ff <= RST_POWER_CONTROL[BIT_COIN_CELL_MEASURE_START];
    end else if (cc_start) begin
      coin_cell_measure_start_ff <= 1'b1;
    end else if (coin_cell_done) begin
      coin_cell_measure_start_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coin_cell_pulse_ff <= 1'b0;
    end else begin
      coin_cell_pulse_ff <= cc_start;
    end
  end

  // key write arms one protected write; any other write disarms
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlocked_ff <= 1'b0;
    end else if (reg_wr) begin
      unlocked_ff <= (reg_addr == ADDR_UNLOCK_KEY) && (reg_wdata == UNLOCK_KEY_VALUE);
    end
  end

  // power-fail state machine
  always_comb begin
    nxt_pf_state = pf_state_ff;
    case (pf_state_ff)
      PF_RUN: begin
        if (pf_trip) begin
          nxt_pf_state = PF_OFF;
        end
      end
      PF_OFF: begin
        if (seq_powerup) begin
          nxt_pf_state = PF_RUN;
        end
      end
      default: begin
        nxt_pf_state = PF_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_state_ff <= PF_RUN;
    end else begin
      pf_state_ff <= nxt_pf_state;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rails_off_ff <= 1'b0;
    end else begin
      rails_off_ff <= (nxt_pf_state == PF_OFF);
    end
  end

  // converter enables: software, then sequencer, then seal, then shutdown
  always_comb begin
    nxt_conv_en = conv_en_ff;
    if (wr_en) begin
      nxt_conv_en = reg_wdata[CONV_COUNT-1:0];
    end
    if (seq_en_we) begin
      nxt_conv_en[SEQ_CONV_COUNT-1:0] = seq_en_val;
    end
    if (factory_seal) begin
      nxt_conv_en[BIT_BACKUP_BUCK_A_ENABLE] = nxt_conv_en[BIT_BACKUP_BUCK_A_ENABLE] |
        conv_en_ff[BIT_BACKUP_BUCK_A_ENABLE];
      nxt_conv_en[BIT_BACKUP_BUCK_B_ENABLE] = nxt_conv_en[BIT_BACKUP_BUCK_B_ENABLE] |
        conv_en_ff[BIT_BACKUP_BUCK_B_ENABLE];
    end
    if ((pf_state_ff == PF_RUN) && pf_trip) begin
      nxt_conv_en = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_en_ff <= RST_CONVERTER_ENABLES[CONV_COUNT-1:0];
    end else begin
      conv_en_ff <= nxt_conv_en;
    end
  end

  // device state code
  always_comb begin
    nxt_dev_state = DS_TRANSITION;
    if (pf_state_ff == PF_OFF) begin
      nxt_dev_state = DS_TRANSITION;
    end else if (seq_suspend) begin
      nxt_dev_state = DS_SUSPEND;
    end else if (seq_active) begin
      nxt_dev_state = DS_ACTIVE;
    end else if (seq_wait_pwr_en) begin
      nxt_dev_state = DS_WAIT_PWR_EN;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_state_ff <= DS_TRANSITION;
    end else begin
      dev_state_ff <= nxt_dev_state;
    end
  end

  // read mux; unmapped and key reads give zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      ADDR_POWER_CONTROL: begin
        nxt_rdata[BIT_POWER_FAIL_SHUTDOWN_EN] = power_fail_shutdown_en_ff;
        nxt_rdata[BIT_COIN_CELL_MEASURE_START] = coin_cell_measure_start_ff;
      end
      ADDR_SUSPEND_RAIL_FLAGS: begin
        nxt_rdata = flag_if.flags;
      end
      ADDR_UNLOCK_KEY: begin
        nxt_rdata = 8'h00;
      end
      ADDR_CONVERTER_ENABLES: begin
        nxt_rdata[CONV_COUNT-1:0] = conv_en_ff;
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_pf_ignored: assert property (
    (pf_state_ff == PF_RUN && !power_fail_shutdown_en_ff) |=>
      (pf_state_ff == PF_RUN && !rails_off_ff))
    else $error("power-fail acted while shutdown bit clear");

  chk_pf_shutdown: assert property (
    (pf_state_ff == PF_RUN && power_fail_shutdown_en_ff && !power_fail_out_n) |=>
      (rails_off_ff && conv_en_ff == '0 && pf_state_ff == PF_OFF))
    else $error("power-fail trip did not shut rails down");

  chk_cc_start: assert property (
    cc_start |=> (coin_cell_pulse_ff && coin_cell_measure_start_ff) ##1 !coin_cell_pulse_ff)
    else $error("coin-cell start not one pulse");

  chk_cc_zero_write: assert property (
    (wr_ctl && !reg_wdata[BIT_COIN_CELL_MEASURE_START]) |=> !coin_cell_pulse_ff)
    else $error("writing zero started a measurement");

  chk_flag_read: assert property (
    reg_rd && reg_addr == ADDR_SUSPEND_RAIL_FLAGS |=>
      (reg_rvalid_ff && reg_rdata_ff == $past(flag_if.flags)))
    else $error("flag register read mismatch");

  chk_key_reads_zero: assert property (
    reg_rd && reg_addr == ADDR_UNLOCK_KEY |=> (reg_rvalid_ff && reg_rdata_ff == 8'h00))
    else $error("unlock key read not zero");

  chk_locked_write: assert property (
    (reg_wr && reg_addr == ADDR_CONVERTER_ENABLES && !unlocked_ff && !seq_en_we &&
      !(pf_state_ff == PF_RUN && pf_trip)) |=> $stable(conv_en_ff))
    else $error("locked enable write took effect");

  chk_en_write: assert property (
    (wr_en && !seq_en_we && !factory_seal && !(pf_state_ff == PF_RUN && pf_trip)) |=>
      (conv_en_ff == $past(reg_wdata[CONV_COUNT-1:0])) ##1 !unlocked_ff)
    else $error("enable write not applied");

  chk_seq_update: assert property (
    (seq_en_we && !(pf_state_ff == PF_RUN && pf_trip)) |=>
      (conv_en_ff[SEQ_CONV_COUNT-2:0] == $past(seq_en_val[SEQ_CONV_COUNT-2:0])))
    else $error("sequencer update not applied");

  chk_seal_hold: assert property (
    (factory_seal && conv_en_ff[BIT_BACKUP_BUCK_B_ENABLE] &&
      !(pf_state_ff == PF_RUN && pf_trip)) |=> conv_en_ff[BIT_BACKUP_BUCK_B_ENABLE])
    else $error("sealed backup converter was disabled");

  chk_state_code: assert property (
    (pf_state_ff == PF_RUN && seq_suspend) |=> (dev_state_ff == DS_SUSPEND))
    else $error("suspend state code wrong");

  chk_reserved_zero: assert property (
    reg_rd && reg_addr == ADDR_CONVERTER_ENABLES |=> (reg_rdata_ff[7:CONV_COUNT] == '0))
    else $error("reserved enable bits not zero");

  cov_pf_shutdown: cover property (pf_state_ff == PF_RUN ##1 pf_state_ff == PF_OFF);
  cov_cc_measure: cover property (cc_start ##[1:20] coin_cell_done);
  cov_unlocked_write: cover property (wr_en);
  cov_suspend_powerup: cover property (seq_suspend ##[1:20] (seq_powerup && seq_from_suspend));

endmodule

// ==== verilog/pcr_suspend_flags.sv ====
`timescale 1ns/10ps
module pcr_suspend_flags
  import pcr_pkg::*;
#(
  parameter int N = FLAG_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sequencer side
  pcr_flag_if.capture fi
);

  logic [N-1:0] snap_ff;
  logic [N-1:0] flags_ff;

  // rail enables seen during suspend
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_ff <= '0;
    end else if (fi.in_suspend) begin
      snap_ff <= fi.rail_en;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff <= N'(RST_SUSPEND_RAIL_FLAGS);
    end else if (fi.powerup) begin
      if (fi.from_suspend) begin
        flags_ff <= snap_ff;
      end else begin
        flags_ff <= '0;
      end
    end
  end

  assign fi.flags = flags_ff;

  chk_flag_from_suspend: assert property (@(posedge clk) disable iff (sys_rst)
    (fi.powerup && fi.from_suspend) |=> (fi.flags == $past(snap_ff)))
    else $error("flags do not match rails enabled in suspend");

  chk_flag_from_off: assert property (@(posedge clk) disable iff (sys_rst)
    (fi.powerup && !fi.from_suspend) |=> (fi.flags == '0))
    else $error("flags not clear after power-up from off");

  // flags only move on a power-up event
  chk_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !fi.powerup |=> (fi.flags == $past(fi.flags)))
    else $error("flags changed without a power-up");

endmodule
